// [rtl/timer16_gate_regs.vh]
// register offsets, field positions and reset values of the gated 16-bit timer
// assumes inclusion by bare name from the design file
`ifndef TIMER16_GATE_REGS_VH
`define TIMER16_GATE_REGS_VH

// register offsets on the plain register port
`define ADDR_CTRL       4'h0
`define ADDR_GATE       4'h1
`define ADDR_COUNT_LO   4'h2
`define ADDR_COUNT_HI   4'h3
`define ADDR_FLAGS      4'h4
`define ADDR_IRQ_EN     4'h5
`define ADDR_CAPT_LO    4'h6
`define ADDR_CAPT_HI    4'h7
`define ADDR_CMP_LO     4'h8
`define ADDR_CMP_HI     4'h9
`define ADDR_PMD        4'ha

// control register fields
`define CTRL_ON         0
`define CTRL_SYNC_DIS   2
`define CTRL_SOSC_EN    3
`define CTRL_CS_LO      6
`define CTRL_CS_HI      7

// gate register fields
`define GATE_SS_LO      0
`define GATE_SS_HI      1
`define GATE_VAL        2
`define GATE_ARM        3
`define GATE_SPM        4
`define GATE_TM         5
`define GATE_POL        6
`define GATE_EN         7

// flag and enable fields
`define FLAG_OVF        0
`define FLAG_GATE       1
`define FLAG_CMP        2

// gate source encodings
`define GSS_PIN         2'h0
`define GSS_PERIOD      2'h1
`define GSS_CMP1        2'h2
`define GSS_CMP2        2'h3

// clock source encodings
`define CS_INSTR        2'h0
`define CS_SYS          2'h1
`define CS_EXT          2'h2

// reset values and count maximum
`define RST_CTRL        8'h00
`define RST_GATE        8'h00
`define RST_COUNT       16'h0000
`define COUNT_MAX       16'hffff

`endif

// [rtl/timer16_gate_control.v]
// gated 16-bit timer/counter: gate sources, toggle and single-pulse modes,
// gate and overflow flags, capture/compare time base, module disable.
// assumes all inputs synchronous to clk_sys; tick inputs are one-cycle pulses.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_gate_regs.vh"

module timer16_gate_control (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // register port
  input  wire [3:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdata,
  // clock sources: instruction tick is a one-cycle pulse, external pin and oscillator are edge-detected
  input  wire        instrTick,
  input  wire        extClkPin,
  input  wire        secOscClk,
  // gate sources
  input  wire        gate_input_pin,
  input  wire        partnerPeriodMatch,
  input  wire        comparatorOneOut,
  input  wire        comparatorTwoOut,
  // capture/compare and power
  input  wire        captureEvent,
  input  wire        specialEventTrigger,
  input  wire        sleepMode,
  // outputs
  output wire        overflowIrq,
  output wire        gateEventIrq,
  output reg         compareEvent,
  output wire        wakeRequest,
  output wire        secOscRun
);

  // software registers
  reg  [7:0]  ctrl;
  reg  [1:0]  gate_source_select;
  reg         gate_single_pulse_enable;
  reg         gate_toggle_enable;
  reg         gate_polarity;
  reg         gate_enable;
  reg         single_pulse_arm_done;
  reg         overflow_flag;
  reg         gate_event_flag;
  reg         compareFlag;
  reg  [2:0]  irqEnable;
  reg         module_disable_bit;
  reg  [1:0]  cmpSyncSel;
  reg  [15:0] count_pair;
  reg  [15:0] capture_compare_pair;
  reg  [15:0] comparePair;
  // gate path state
  reg         cmpOneSync;
  reg         cmpTwoSync;
  reg         periodSeen;
  reg         periodPulse;
  reg         toggleFf;
  reg         gateLevelPrev;
  reg         spmRun;
  reg         extPrev;
  reg         oscPrev;

  wire        timer_on      = ctrl[`CTRL_ON];
  wire        sync_disable  = ctrl[`CTRL_SYNC_DIS];
  wire [1:0]  clock_source_select = ctrl[`CTRL_CS_HI:`CTRL_CS_LO];
  wire        secondary_osc_enable = ctrl[`CTRL_SOSC_EN];

  // decode a write strobe for one address
  function wrHit;
    input [3:0] a;
    input [3:0] target;
    input       we;
    begin
      wrHit = we && (a == target);
    end
  endfunction

  wire wrCtrl  = wrHit(regAddr, `ADDR_CTRL, regWrite);
  wire wrGate  = wrHit(regAddr, `ADDR_GATE, regWrite);
  wire wrLo    = wrHit(regAddr, `ADDR_COUNT_LO, regWrite);
  wire wrHi    = wrHit(regAddr, `ADDR_COUNT_HI, regWrite);
  wire wrFlags = wrHit(regAddr, `ADDR_FLAGS, regWrite);
  wire wrIrqEn = wrHit(regAddr, `ADDR_IRQ_EN, regWrite);
  wire wrCmpLo = wrHit(regAddr, `ADDR_CMP_LO, regWrite);
  wire wrCmpHi = wrHit(regAddr, `ADDR_CMP_HI, regWrite);
  wire wrPmd   = wrHit(regAddr, `ADDR_PMD, regWrite);

  // timer clock edge from the selected source
  wire extSrc = secondary_osc_enable ? secOscClk : extClkPin;
  wire extRise = secondary_osc_enable ? (secOscClk & ~oscPrev) : (extClkPin & ~extPrev);
  reg  clkEdge;
  always @* begin
    case (clock_source_select)
      `CS_SYS:  clkEdge = 1'b1;
      `CS_EXT:  clkEdge = extRise;
      default:  clkEdge = instrTick;
    endcase
  end
  // in sleep only the asynchronous external counter keeps running
  wire sleepOk = ~sleepMode | (sync_disable & (clock_source_select == `CS_EXT));
  wire timerClk = clkEdge & sleepOk & ~module_disable_bit;

  // secondary oscillator runs whenever enabled, sleep or not
  assign secOscRun = secondary_osc_enable & ~module_disable_bit;

  // gate source mux
  wire cmpOne = cmpSyncSel[0] ? cmpOneSync : comparatorOneOut;
  wire cmpTwo = cmpSyncSel[1] ? cmpTwoSync : comparatorTwoOut;
  reg  gateSrc;
  always @* begin
    case (gate_source_select)
      `GSS_PIN:    gateSrc = gate_input_pin;
      `GSS_PERIOD: gateSrc = periodPulse;
      `GSS_CMP1:   gateSrc = cmpOne;
      `GSS_CMP2:   gateSrc = cmpTwo;
      default:     gateSrc = 1'b0;
    endcase
  end

  // polarity, toggle and single-pulse stages
  wire polGate   = gateSrc ^ ~gate_polarity;
  wire toggleIn  = gate_toggle_enable ? toggleFf : polGate;
  wire gate_level_status = gate_single_pulse_enable ?
                           (toggleIn & spmRun) : toggleIn;
  wire gateQual  = gate_enable ? gate_level_status : 1'b1;
  wire incEn     = timer_on & gateQual & timerClk;

  // comparator synchronisers on the timer clock, period pulse shaping
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmpOneSync  <= 1'b0;
      cmpTwoSync  <= 1'b0;
      periodSeen  <= 1'b0;
      periodPulse <= 1'b0;
      extPrev     <= 1'b0;
      oscPrev     <= 1'b0;
    end else begin
      if (timerClk) begin
        cmpOneSync <= comparatorOneOut;
        cmpTwoSync <= comparatorTwoOut;
      end
      // match is followed by wrap to zero; the wrap gives the rising pulse
      periodSeen  <= partnerPeriodMatch;
      periodPulse <= periodSeen & ~partnerPeriodMatch;
      extPrev     <= extClkPin;
      oscPrev     <= extSrc;
    end
  end

  // toggle flip-flop and its rising-edge detector
  reg  gateLevelPrevSrc;
  wire polRise = polGate & ~gateLevelPrevSrc;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      toggleFf         <= 1'b0;
      gateLevelPrevSrc <= 1'b0;
    end else if (module_disable_bit || !timer_on) begin
      toggleFf         <= 1'b0;
      gateLevelPrevSrc <= 1'b0;
    end else begin
      gateLevelPrevSrc <= polGate;
      if (!gate_toggle_enable)
        toggleFf <= 1'b0;
      else if (polRise)
        toggleFf <= ~toggleFf;
    end
  end

  // count, flags and control registers
  wire gateFall  = gateLevelPrev & ~gate_level_status;
  wire gateRise  = ~gateLevelPrev & toggleIn;
  wire wrap      = incEn && (count_pair == `COUNT_MAX);
  wire [15:0] nextCount = count_pair + 16'h0001;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl                     <= `RST_CTRL;
      gate_source_select       <= 2'h0;
      gate_single_pulse_enable <= 1'b0;
      gate_toggle_enable       <= 1'b0;
      gate_polarity            <= 1'b0;
      gate_enable              <= 1'b0;
      single_pulse_arm_done    <= 1'b0;
      spmRun                   <= 1'b0;
      overflow_flag            <= 1'b0;
      gate_event_flag          <= 1'b0;
      compareFlag              <= 1'b0;
      irqEnable                <= 3'h0;
      cmpSyncSel               <= 2'h0;
      module_disable_bit       <= 1'b0;
      count_pair               <= `RST_COUNT;
      capture_compare_pair     <= `RST_COUNT;
      comparePair              <= 16'hffff;
      gateLevelPrev            <= 1'b0;
      compareEvent             <= 1'b0;
    end else begin
      if (wrPmd)
        module_disable_bit <= regWdata[0];
      if (module_disable_bit) begin
        ctrl                     <= `RST_CTRL;
        gate_source_select       <= 2'h0;
        gate_single_pulse_enable <= 1'b0;
        gate_toggle_enable       <= 1'b0;
        gate_polarity            <= 1'b0;
        gate_enable              <= 1'b0;
        single_pulse_arm_done    <= 1'b0;
        spmRun                   <= 1'b0;
        overflow_flag            <= 1'b0;
        gate_event_flag          <= 1'b0;
        compareFlag              <= 1'b0;
        irqEnable                <= 3'h0;
        count_pair               <= `RST_COUNT;
        gateLevelPrev            <= 1'b0;
        compareEvent             <= 1'b0;
      end else begin
        gateLevelPrev <= gate_level_status;
        if (wrCtrl)
          ctrl <= regWdata;
        if (wrIrqEn)
          irqEnable <= regWdata[2:0];
        if (wrCmpLo)
          comparePair[7:0] <= regWdata;
        if (wrCmpHi)
          comparePair[15:8] <= regWdata;
        // gate control; arm/done also driven by hardware
        if (wrGate) begin
          gate_enable              <= regWdata[`GATE_EN];
          gate_polarity            <= regWdata[`GATE_POL];
          gate_toggle_enable       <= regWdata[`GATE_TM];
          gate_single_pulse_enable <= regWdata[`GATE_SPM];
          gate_source_select       <= regWdata[`GATE_SS_HI:`GATE_SS_LO];
          cmpSyncSel               <= regWdata[`GATE_SS_HI:`GATE_SS_LO] == `GSS_CMP1 ?
                                      {cmpSyncSel[1], regWdata[`GATE_VAL]} :
                                      {regWdata[`GATE_VAL], cmpSyncSel[0]};
        end
        if (wrGate && !regWdata[`GATE_SPM]) begin
          single_pulse_arm_done <= 1'b0;
          spmRun                <= 1'b0;
        end else if (wrGate && regWdata[`GATE_ARM] && !single_pulse_arm_done) begin
          single_pulse_arm_done <= 1'b1;
          spmRun                <= 1'b0;
        end else if (single_pulse_arm_done && !spmRun && gateRise && timer_on) begin
          spmRun <= 1'b1;
        end else if (spmRun && gateFall) begin
          single_pulse_arm_done <= 1'b0;
          spmRun                <= 1'b0;
        end
        // count: write wins over trigger, trigger clears without flag
        if (wrLo)
          count_pair[7:0] <= regWdata;
        if (wrHi)
          count_pair[15:8] <= regWdata;
        if (!wrLo && !wrHi) begin
          if (specialEventTrigger)
            count_pair <= `RST_COUNT;
          else if (incEn)
            count_pair <= nextCount;
        end
        // capture and compare time base
        if (captureEvent)
          capture_compare_pair <= count_pair;
        compareEvent <= timer_on && (count_pair == comparePair);
        // sticky flags: hardware set wins over software clear
        if (wrap && !specialEventTrigger && !wrLo && !wrHi)
          overflow_flag <= 1'b1;
        else if (wrFlags && !regWdata[`FLAG_OVF])
          overflow_flag <= 1'b0;
        if (gateFall)
          gate_event_flag <= 1'b1;
        else if (wrFlags && !regWdata[`FLAG_GATE])
          gate_event_flag <= 1'b0;
        if (timer_on && count_pair == comparePair && !compareEvent)
          compareFlag <= 1'b1;
        else if (wrFlags && !regWdata[`FLAG_CMP])
          compareFlag <= 1'b0;
      end
    end
  end

  // request outputs
  assign overflowIrq  = overflow_flag & irqEnable[`FLAG_OVF];
  assign gateEventIrq = gate_event_flag & irqEnable[`FLAG_GATE];
  assign wakeRequest  = sleepMode & overflowIrq;

  // read data, one cycle after the strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `ADDR_CTRL:     regRdata <= ctrl;
        `ADDR_GATE:     regRdata <= {gate_enable, gate_polarity, gate_toggle_enable,
                                     gate_single_pulse_enable, single_pulse_arm_done,
                                     gate_level_status, gate_source_select};
        `ADDR_COUNT_LO: regRdata <= count_pair[7:0];
        `ADDR_COUNT_HI: regRdata <= count_pair[15:8];
        `ADDR_FLAGS:    regRdata <= {5'h00, compareFlag, gate_event_flag, overflow_flag};
        `ADDR_IRQ_EN:   regRdata <= {5'h00, irqEnable};
        `ADDR_CAPT_LO:  regRdata <= capture_compare_pair[7:0];
        `ADDR_CAPT_HI:  regRdata <= capture_compare_pair[15:8];
        `ADDR_CMP_LO:   regRdata <= comparePair[7:0];
        `ADDR_CMP_HI:   regRdata <= comparePair[15:8];
        `ADDR_PMD:      regRdata <= {5'h00, cmpSyncSel, module_disable_bit};
        default:        regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule // timer16_gate_control
`default_nettype wire

// [dv/timer16_gate_props.sv]
// checker: read data timing, flag outputs, wake request and oscillator run
// assumes bind onto the timer top; one clock domain, async high reset
`timescale 1ns/1ps
`default_nettype none
`include "timer16_gate_regs.vh"
module timer16_gate_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  // power and outputs
  input wire logic       sleepMode,
  input wire logic       overflowIrq,
  input wire logic       gateEventIrq,
  input wire logic       wakeRequest,
  input wire logic       secOscRun
);
  logic       off;
  logic [2:0] irqEn;
  logic       oscEn;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // shadows of module disable, irq enables and oscillator enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      off   <= 1'b0;
      irqEn <= 3'h0;
      oscEn <= 1'b0;
    end else begin
      if (regWrite && regAddr == `ADDR_PMD) off <= regWdata[0];
      if (off) begin
        irqEn <= 3'h0;
        oscEn <= 1'b0;
      end else if (regWrite && regAddr == `ADDR_IRQ_EN) irqEn <= regWdata[2:0];
      else if (regWrite && regAddr == `ADDR_CTRL) oscEn <= regWdata[`CTRL_SOSC_EN];
    end
  end
  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside the answer cycle");
  AST_UNMAPPED: assert property (regRead && regAddr > `ADDR_PMD |=> regRdata == 8'h00)
    else $error("unmapped address read nonzero");
  AST_OFF_READ: assert property ($past(off) && off && regRead && regAddr <= `ADDR_COUNT_HI
    && regAddr != `ADDR_GATE |=> regRdata == 8'h00)
    else $error("disabled timer register not at reset");
  AST_OVF_EN: assert property (overflowIrq |-> irqEn[`FLAG_OVF])
    else $error("overflow irq without enable");
  AST_GATE_EN: assert property (gateEventIrq |-> irqEn[`FLAG_GATE])
    else $error("gate irq without enable");
  AST_OFF_QUIET: assert property (off [*2] |-> !overflowIrq && !gateEventIrq)
    else $error("irq while module disabled");
  AST_WAKE: assert property (wakeRequest == (sleepMode && overflowIrq))
    else $error("wake request mismatch");
  AST_OSC: assert property (secOscRun == (oscEn && !off))
    else $error("oscillator run mismatch");
endmodule // timer16_gate_props
bind timer16_gate_control timer16_gate_props u_props (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .sleepMode(sleepMode),
  .overflowIrq(overflowIrq), .gateEventIrq(gateEventIrq), .wakeRequest(wakeRequest),
  .secOscRun(secOscRun)
);
`default_nettype wire

// [dv/gate_source_model.sv]
// far side: gate pin, two comparators and the paired 8-bit period timer
// assumes the bench requests levels and period matches on clk_sys edges
`timescale 1ns/1ps
`default_nettype none
module gate_source_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // requests from the bench
  input  wire logic [2:0] lvlReq,
  input  wire logic       periodReq,
  // gate sources seen by the timer
  output var  logic       gate_input_pin,
  output var  logic       partnerPeriodMatch,
  output var  logic       comparatorOneOut,
  output var  logic       comparatorTwoOut
);
  // levels and match follow the requests one edge later; match stays high while requested
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {comparatorTwoOut, comparatorOneOut, gate_input_pin} <= 3'h0;
      partnerPeriodMatch <= 1'b0;
    end else begin
      {comparatorTwoOut, comparatorOneOut, gate_input_pin} <= lvlReq;
      partnerPeriodMatch <= periodReq;
    end
  end
endmodule // gate_source_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the gated 16-bit timer over its register port
// assumes the design, its register header, the checker and the source model
`timescale 1ns/1ps
`default_nettype none
`include "timer16_gate_regs.vh"
module testbench;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       captureEvent = 1'b0;
  logic       specialEventTrigger = 1'b0;
  logic       sleepMode = 1'b0;
  logic [2:0] lvlReq = 3'h0;
  logic       periodReq = 1'b0;
  logic [7:0] regRdata, d, cnt;
  logic       gPin, gPer, gC1, gC2, overflowIrq, gateEventIrq, cmpEv, wakeRequest, secOscRun;
  logic [2:0] sel;
  logic [1:0] s;
  int         fails = 0;
  int         cmp_count = 0;
  int         k;
  // clock and design
  always #5 clk_sys = ~clk_sys;
  timer16_gate_control uut (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .instrTick(1'b0),
    .extClkPin(1'b0), .secOscClk(1'b0), .gate_input_pin(gPin), .partnerPeriodMatch(gPer),
    .comparatorOneOut(gC1), .comparatorTwoOut(gC2), .captureEvent(captureEvent),
    .specialEventTrigger(specialEventTrigger), .sleepMode(sleepMode),
    .overflowIrq(overflowIrq), .gateEventIrq(gateEventIrq), .compareEvent(cmpEv),
    .wakeRequest(wakeRequest), .secOscRun(secOscRun));
  gate_source_model u_src (
    .clk_sys(clk_sys), .rst(rst), .lvlReq(lvlReq), .periodReq(periodReq),
    .gate_input_pin(gPin), .partnerPeriodMatch(gPer), .comparatorOneOut(gC1),
    .comparatorTwoOut(gC2));
  // register write, optionally beside a special event trigger
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic t = 1'b0);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    specialEventTrigger <= t;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    specialEventTrigger <= 1'b0;
    #1;
  endtask
  // register read; data stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // selected source to v, the other pin and comparator sources to the opposite level; period match untouched
  task automatic src(input logic [2:0] m, input logic v);
    @(posedge clk_sys);
    lvlReq <= v ? m : ~m;
    idle(4);
  endtask
  task automatic pulsePin;
    src(3'h1, 1'b1);
    src(3'h1, 1'b0);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    wrap_up;
  end
  // test sequence
  initial begin
    idle(5);
    rst <= 1'b0;
    rc(`ADDR_CTRL, 8'hff, `RST_CTRL);
    rc(`ADDR_GATE, 8'hfb, `RST_GATE);
    rc(`ADDR_CMP_LO, 8'hff, 8'hff);
    rc(4'hb, 8'hff, 8'h00);
    // pin and both comparator sources, plain and synchronised, gating off
    wr(`ADDR_IRQ_EN, 8'h02);
    wr(`ADDR_CTRL, 8'h40);
    for (k = 0; k < 6; k++) begin
      s = (k < 2) ? `GSS_PIN : (k < 4) ? `GSS_CMP1 : `GSS_CMP2;
      sel = (k < 2) ? 3'h1 : (k < 4) ? 3'h2 : 3'h4;
      wr(`ADDR_GATE, {6'h10, s} | (k[0] ? 8'h04 : 8'h00));
      src(sel, 1'b1);
      rc(`ADDR_GATE, 8'h04, 8'h04);
      src(sel, 1'b0);
      rc(`ADDR_GATE, 8'h04, 8'h00);
      chk({7'h0, gateEventIrq}, 8'h01);
      wr(`ADDR_FLAGS, 8'h00);
      chk({7'h0, gateEventIrq}, 8'h00);
    end
    // partner period match gives one rising gate pulse
    wr(`ADDR_GATE, 8'h40 | `GSS_PERIOD);
    wr(`ADDR_FLAGS, 8'h00);
    rc(`ADDR_FLAGS, 8'h02, 8'h00);
    @(posedge clk_sys) periodReq <= 1'b1;
    @(posedge clk_sys) periodReq <= 1'b0;
    idle(6);
    rc(`ADDR_FLAGS, 8'h02, 8'h02);
    // gated counting holds while the gate is inactive
    src(3'h1, 1'b0);
    wr(`ADDR_GATE, 8'hc0);
    wr(`ADDR_CTRL, 8'h41);
    idle(8);
    rc(`ADDR_COUNT_LO, 8'hff, 8'h00);
    pulsePin;
    rd(`ADDR_COUNT_LO);
    cnt = d;
    chk({7'h0, cnt != 8'h00}, 8'h01);
    rc(`ADDR_COUNT_LO, 8'hff, cnt);
    // wrap from ffff sets overflow, wakes in sleep
    wr(`ADDR_CTRL, 8'h00);
    wr(`ADDR_GATE, 8'h00);
    wr(`ADDR_COUNT_LO, 8'hff);
    wr(`ADDR_COUNT_HI, 8'hff);
    wr(`ADDR_IRQ_EN, 8'h01);
    rc(`ADDR_FLAGS, 8'h01, 8'h00);
    wr(`ADDR_CTRL, 8'h41);
    wr(`ADDR_CTRL, 8'h00);
    rc(`ADDR_COUNT_HI, 8'hff, 8'h00);
    @(posedge clk_sys) sleepMode <= 1'b1;
    #1 chk({6'h0, wakeRequest, overflowIrq}, 8'h03);
    wr(`ADDR_FLAGS, 8'h00);
    chk({6'h0, wakeRequest, overflowIrq}, 8'h00);
    @(posedge clk_sys) sleepMode <= 1'b0;
    // trigger clears without overflow; a coinciding write wins
    wr(`ADDR_CTRL, 8'h01);
    wr(`ADDR_COUNT_HI, 8'hff);
    wr(4'hc, 8'hff, 1'b1);
    rc(`ADDR_COUNT_HI, 8'hff, 8'h00);
    rc(`ADDR_FLAGS, 8'h01, 8'h00);
    wr(`ADDR_COUNT_LO, 8'h5a, 1'b1);
    @(posedge clk_sys) captureEvent <= 1'b1;
    @(posedge clk_sys) captureEvent <= 1'b0;
    rc(`ADDR_CAPT_LO, 8'hff, 8'h5a);
    // toggle flips on each rising edge; cleared while disabled
    wr(`ADDR_GATE, 8'h40);
    wr(`ADDR_GATE, 8'h60);
    pulsePin;
    rc(`ADDR_GATE, 8'h04, 8'h04);
    pulsePin;
    rc(`ADDR_GATE, 8'h04, 8'h00);
    pulsePin;
    wr(`ADDR_GATE, 8'h40);
    wr(`ADDR_GATE, 8'h60);
    rc(`ADDR_GATE, 8'h04, 8'h00);
    // single pulse: one pulse counted per arming
    wr(`ADDR_GATE, 8'hd0);
    wr(`ADDR_GATE, 8'hd8);
    wr(`ADDR_CTRL, 8'h41);
    rc(`ADDR_GATE, 8'h08, 8'h08);
    pulsePin;
    rc(`ADDR_GATE, 8'h08, 8'h00);
    rd(`ADDR_COUNT_LO);
    cnt = d;
    chk({7'h0, cnt != 8'h5a}, 8'h01);
    pulsePin;
    rc(`ADDR_COUNT_LO, 8'hff, cnt);
    wr(`ADDR_GATE, 8'hd8);
    wr(`ADDR_GATE, 8'hc8);
    rc(`ADDR_GATE, 8'h08, 8'h00);
    wr(`ADDR_GATE, 8'hf0);
    wr(`ADDR_GATE, 8'hf8);
    pulsePin;
    rc(`ADDR_GATE, 8'h08, 8'h08);
    pulsePin;
    rc(`ADDR_GATE, 8'h08, 8'h00);
    // module disable holds the timer at reset
    @(posedge clk_sys) sleepMode <= 1'b1;
    wr(`ADDR_CTRL, 8'h08);
    chk({7'h0, secOscRun}, 8'h01);
    wr(`ADDR_PMD, 8'h01);
    wr(`ADDR_CTRL, 8'h41);
    rc(`ADDR_CTRL, 8'hff, 8'h00);
    rc(`ADDR_COUNT_LO, 8'hff, 8'h00);
    chk({7'h0, secOscRun}, 8'h00);
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
